// ===== common/pnp_frontend_pkg.sv
// Purpose: shared constants for the isa plug-and-play resource front-end
// Assumes: 12-bit isa address decode, 16-bit nonvolatile words
// Notes: record and qualifier field layout is local to this block
package pnp_frontend_pkg;
  // ----------------------------------------------------------------
  // nonvolatile memory layout
  // ----------------------------------------------------------------
  localparam int MEM_WORDS = 256;
  localparam logic [7:0] PNP_AREA_W = 8'h00; // lower half: resource data
  localparam logic [7:0] LEGACY_AREA_W = 8'h80; // upper half: legacy records
  localparam logic [7:0] LEGACY_BASE_W = 8'h84; // record of strap code zero
  localparam logic [1:0] REC_LAST = 2'h3; // four words per record
  localparam logic [4:0] STRAP_SW_WRITE = 5'h1F;
  // ----------------------------------------------------------------
  // qualifier word (record word 0) and routing word fields
  // ----------------------------------------------------------------
  localparam int QF_MODE = 0; // 1 = extended interrupt mode
  localparam int QF_QUAL_A = 1; // bits 1..3: strobe qualify per select
  localparam int QF_WAND_B = 4;
  localparam int QF_WAND_C = 5;
  localparam int QF_OD_LO = 6; // bits 6..13: open-drain per channel
  localparam int QF_WP_OFF = 15; // 0 = memory write protected
  localparam int WF_BASE_HI = 11; // words 1..3: select base in 11..0
  localparam int WF_SEL_LO = 12; // words 1,2: irq channel, word 3: dma
  // ----------------------------------------------------------------
  // isa plug-and-play ports, key and registers
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_PORT = 12'h279;
  localparam logic [11:0] WDATA_PORT = 12'hA79;
  localparam logic [9:0] RD_PORT_SW = 10'h203;
  localparam logic [7:0] LFSR_SEED = 8'h6A;
  localparam logic [5:0] KEY_LAST = 6'h1F; // 32 key bytes
  localparam logic [7:0] EXT_KEY_BYTE = 8'h9C;
  localparam logic [7:0] REG_RD_PORT = 8'h00;
  localparam logic [7:0] REG_CFG_CTL = 8'h02;
  localparam logic [7:0] REG_ACTIVATE = 8'h30;
  localparam logic [7:0] REG_IO_HI = 8'h60;
  localparam logic [7:0] REG_IO_LO = 8'h61;
  localparam logic [7:0] REG_IRQ = 8'h70;
  localparam logic [7:0] REG_DMA = 8'h74;
  localparam int CTL_WAIT_KEY = 1;
  localparam int DMA_IRQ_CH = 6;
  localparam int IRQ_CH = 8;
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11
  } boot_st_t;
endpackage

// ===== rtl/isa_pnp_resource_frontend.sv
// Purpose: isa card front-end: selects, irq/dma routing, pnp or legacy config
// Assumes: all pins synchronous to sys_clk; pad ring supplies pull-ups
// Notes: pnp protocol is reduced to key, address/data ports and core regs
//
// What this block does
// - two modes, DMA or extended interrupt
// - DMA mode: two selects, optional wire-AND
// - DMA mode: two irqs onto six channels
// - DMA mode: each channel totem or open-drain
// - DMA mode: one drq onto two channels
// - extended mode: three selects, optional wire-AND
// - extended mode: one irq onto eight channels
// - extended mode: each channel totem or open-drain
// - select pin high at reset: pnp interface
// - select pin pulled up, open means pnp
// - pnp mode runs configuration protocol and registers
// - legacy mode ignores protocol, self-configures, except code 31
// - select low: legacy, straps sampled too
// - 31 stored records, code 31 field-programming
// - fewer connected straps still work
// - straps pulled up, open reads one
// - record is four words, loaded at start
// - memory split legacy area and pnp area
// - write protection blocks all memory writes
// - qualifier bit 15 zero protects; override
// - key plus 0x9C enters config, programming
// - field-programming read port defaults 0x203
`timescale 1ns/10ps
module isa_pnp_resource_frontend (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic isa_reset_drive,
  input wire logic legacy_interface_sel_n,
  input wire logic [4:0] legacy_strap,
  input wire logic [11:0] isa_addr,
  input wire logic isa_aen,
  input wire logic isa_iord_n,
  input wire logic isa_iowr_n,
  input wire logic [7:0] isa_data_in,
  output logic [7:0] isa_data_out,
  output logic isa_data_oe_n,
  input wire logic [1:0] local_irq,
  input wire logic local_drq,
  input wire logic [1:0] isa_dack_n,
  output logic local_dack_n,
  output logic [1:0] isa_drq,
  output logic [7:0] isa_irq,
  output logic [7:0] isa_irq_oe_n,
  output logic card_select_a_n,
  output logic card_select_b_n,
  output logic card_select_c_n,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  output logic pnp_interface,
  output logic config_state,
  output logic write_protected
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // state and derived configuration
  // ----------------------------------------------------------------
  pnp_frontend_pkg::boot_st_t st_q, st_d;
  logic pnp_q, pnp_d, cfg_q, cfg_d;
  logic [4:0] strap_q, strap_d;
  logic [1:0] ld_q, ld_d;
  logic [3:0][15:0] rec_q, rec_d;
  logic [15:0] mem_q [pnp_frontend_pkg::MEM_WORDS];
  logic [7:0] rd_addr, lfsr_q, lfsr_d, padr_q, padr_d, dout_d;
  logic [5:0] kcnt_q, kcnt_d;
  logic keyok_q, keyok_d, act_q, act_d, iowr_prev_q, doe_d;
  logic [9:0] rdp_q, rdp_d;
  logic [11:0] iob_q, iob_d;
  logic [3:0] irql_q, irql_d;
  logic [2:0] dmac_q, dmac_d, cs_hit, cs_d, chan0, chan1;
  logic [2:0][11:0] cs_base;
  logic [7:0] irq_d, irqoe_d;
  logic [1:0] drq_d;
  logic sw_cfg, ext, wp, wr_stb, run_ok, dsel, mem_we, rd_hit, pcfg_d, dack_d;

  assign sw_cfg = !pnp_q && strap_q == pnp_frontend_pkg::STRAP_SW_WRITE;
  assign ext = rec_q[0][pnp_frontend_pkg::QF_MODE];
  // the field-programming config forces protection off
  assign wp = !rec_q[0][pnp_frontend_pkg::QF_WP_OFF] && !sw_cfg;
  assign mem_we = mem_wr_en && config_state && !wp;
  // isa data is valid at the trailing edge of the write strobe
  assign wr_stb = isa_iowr_n && !iowr_prev_q && !isa_aen;
  assign run_ok = st_q == pnp_frontend_pkg::ST_RUN && cfg_q && (!pnp_q || act_q);
  assign chan0 = pnp_q ? irql_q[2:0] : rec_q[1][pnp_frontend_pkg::WF_SEL_LO +: 3];
  assign chan1 = rec_q[2][pnp_frontend_pkg::WF_SEL_LO +: 3];
  assign dsel = pnp_q ? dmac_q[0] : rec_q[3][pnp_frontend_pkg::WF_SEL_LO];
  // record of strap code s sits at 0x84 + 4*s in the legacy area
  assign rd_addr = (pnp_q ? pnp_frontend_pkg::PNP_AREA_W
                   : pnp_frontend_pkg::LEGACY_BASE_W + {1'b0, strap_q, 2'b00})
                   + {6'h00, ld_q};

  // ----------------------------------------------------------------
  // nonvolatile store
  // ----------------------------------------------------------------
  // data array, no reset: contents survive isa resets
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem_q[mem_wr_addr] <= mem_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // boot: sample pins, load record
  // ----------------------------------------------------------------
  // sampling once after release keeps later strap moves harmless
  always_comb begin
    st_d = st_q;
    pnp_d = pnp_q;
    strap_d = strap_q;
    ld_d = ld_q;
    rec_d = rec_q;
    cfg_d = cfg_q;
    if (isa_reset_drive) begin
      st_d = pnp_frontend_pkg::ST_SAMPLE;
      cfg_d = 1'b0;
    end else begin
      unique case (st_q)
        pnp_frontend_pkg::ST_SAMPLE: begin
          // open pins read one through the pad pull-ups
          pnp_d = legacy_interface_sel_n;
          strap_d = legacy_strap;
          ld_d = 2'h0;
          rec_d = '0;
          st_d = pnp_frontend_pkg::ST_LOAD;
        end
        pnp_frontend_pkg::ST_LOAD: begin
          if (sw_cfg) begin
            st_d = pnp_frontend_pkg::ST_RUN; // no stored record for code 31
          end else begin
            rec_d[ld_q] = mem_q[rd_addr];
            ld_d = ld_q + 2'h1;
            if (ld_q == pnp_frontend_pkg::REC_LAST) begin
              cfg_d = 1'b1;
              st_d = pnp_frontend_pkg::ST_RUN;
            end
          end
        end
        pnp_frontend_pkg::ST_RUN: begin
          st_d = pnp_frontend_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= pnp_frontend_pkg::ST_SAMPLE;
      pnp_q <= 1'b1;
      strap_q <= '0;
      ld_q <= '0;
      rec_q <= '0;
      cfg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pnp_q <= pnp_d;
      strap_q <= strap_d;
      ld_q <= ld_d;
      rec_q <= rec_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // plug-and-play key and registers
  // ----------------------------------------------------------------
  // no isolation sequence: one card assumed on the bus
  always_comb begin
    lfsr_d = lfsr_q;
    kcnt_d = kcnt_q;
    keyok_d = keyok_q;
    pcfg_d = config_state;
    padr_d = padr_q;
    rdp_d = rdp_q;
    act_d = act_q;
    iob_d = iob_q;
    irql_d = irql_q;
    dmac_d = dmac_q;
    if (isa_reset_drive) begin
      lfsr_d = pnp_frontend_pkg::LFSR_SEED;
      kcnt_d = '0;
      keyok_d = 1'b0;
      pcfg_d = 1'b0;
      rdp_d = '0;
      act_d = 1'b0;
    end else if (wr_stb && st_q == pnp_frontend_pkg::ST_RUN && (pnp_q || sw_cfg)) begin
      if (isa_addr == pnp_frontend_pkg::ADDR_PORT) begin
        padr_d = isa_data_in;
        if (!config_state && keyok_q) begin
          keyok_d = 1'b0;
          pcfg_d = isa_data_in == pnp_frontend_pkg::EXT_KEY_BYTE;
          rdp_d = pnp_frontend_pkg::RD_PORT_SW;
        end else if (!config_state && isa_data_in == lfsr_q) begin
          lfsr_d = {lfsr_q[1] ^ lfsr_q[0], lfsr_q[7:1]};
          kcnt_d = kcnt_q + 6'h01;
          if (kcnt_q == pnp_frontend_pkg::KEY_LAST) begin
            keyok_d = sw_cfg; // field programming wants one more byte
            pcfg_d = !sw_cfg;
            lfsr_d = pnp_frontend_pkg::LFSR_SEED;
            kcnt_d = '0;
          end
        end else if (!config_state) begin
          lfsr_d = pnp_frontend_pkg::LFSR_SEED;
          kcnt_d = '0;
        end
      end else if (isa_addr == pnp_frontend_pkg::WDATA_PORT && config_state) begin
        unique case (padr_q)
          pnp_frontend_pkg::REG_RD_PORT: rdp_d = {isa_data_in, 2'b11};
          pnp_frontend_pkg::REG_CFG_CTL: pcfg_d = !isa_data_in[pnp_frontend_pkg::CTL_WAIT_KEY];
          pnp_frontend_pkg::REG_ACTIVATE: act_d = isa_data_in[0];
          pnp_frontend_pkg::REG_IO_HI: iob_d[11:8] = isa_data_in[3:0];
          pnp_frontend_pkg::REG_IO_LO: iob_d[7:0] = isa_data_in;
          pnp_frontend_pkg::REG_IRQ: irql_d = isa_data_in[3:0];
          pnp_frontend_pkg::REG_DMA: dmac_d = isa_data_in[2:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= pnp_frontend_pkg::LFSR_SEED;
      kcnt_q <= '0;
      keyok_q <= 1'b0;
      config_state <= 1'b0;
      padr_q <= '0;
      rdp_q <= '0;
      act_q <= 1'b0;
      iob_q <= '0;
      irql_q <= '0;
      dmac_q <= '0;
      iowr_prev_q <= 1'b1;
    end else begin
      lfsr_q <= lfsr_d;
      kcnt_q <= kcnt_d;
      keyok_q <= keyok_d;
      config_state <= pcfg_d;
      padr_q <= padr_d;
      rdp_q <= rdp_d;
      act_q <= act_d;
      iob_q <= iob_d;
      irql_q <= irql_d;
      dmac_q <= dmac_d;
      iowr_prev_q <= isa_iowr_n;
    end
  end

  // ----------------------------------------------------------------
  // decode and routing
  // ----------------------------------------------------------------
  assign cs_base[0] = pnp_q ? iob_q : rec_q[1][pnp_frontend_pkg::WF_BASE_HI:0];
  assign cs_base[1] = rec_q[2][pnp_frontend_pkg::WF_BASE_HI:0];
  assign cs_base[2] = rec_q[3][pnp_frontend_pkg::WF_BASE_HI:0];

  // select c exists only in extended mode
  for (genvar i = 0; i < 3; i++) begin : g_cs
    assign cs_hit[i] = run_ok && (i < 2 || ext) && !isa_aen && isa_addr == cs_base[i]
                       && (!rec_q[0][pnp_frontend_pkg::QF_QUAL_A + i]
                           || !isa_iord_n || !isa_iowr_n);
  end

  // open-drain only pulls low while asserted, so the line can be shared
  for (genvar ch = 0; ch < pnp_frontend_pkg::IRQ_CH; ch++) begin : g_irq
    logic own, req, od;
    assign od = rec_q[0][pnp_frontend_pkg::QF_OD_LO + ch];
    assign own = run_ok && (ext ? chan0 == 3'(ch)
                 : ch < pnp_frontend_pkg::DMA_IRQ_CH && (chan0 == 3'(ch) || chan1 == 3'(ch)));
    assign req = (chan0 == 3'(ch) && local_irq[0])
                 || (!ext && chan1 == 3'(ch) && local_irq[1]);
    assign irq_d[ch] = od ? 1'b0 : own && req;
    assign irqoe_d[ch] = !(own && (!od || req));
  end

  assign rd_hit = !isa_iord_n && !isa_aen && config_state && rdp_q != '0
                  && isa_addr == {2'b00, rdp_q};
  always_comb begin
    dout_d = 8'h00;
    unique case (padr_q)
      pnp_frontend_pkg::REG_RD_PORT: dout_d = rdp_q[9:2];
      pnp_frontend_pkg::REG_ACTIVATE: dout_d = {7'h00, act_q};
      pnp_frontend_pkg::REG_IO_HI: dout_d = {4'h0, iob_q[11:8]};
      pnp_frontend_pkg::REG_IO_LO: dout_d = iob_q[7:0];
      pnp_frontend_pkg::REG_IRQ: dout_d = {4'h0, irql_q};
      pnp_frontend_pkg::REG_DMA: dout_d = {5'h00, dmac_q};
      default: dout_d = 8'h00;
    endcase
    doe_d = !rd_hit;
    // wire-AND: select a also falls when b or c is chosen to join it
    cs_d[0] = !(cs_hit[0] || (rec_q[0][pnp_frontend_pkg::QF_WAND_B] && cs_hit[1])
                || (rec_q[0][pnp_frontend_pkg::QF_WAND_C] && cs_hit[2]));
    cs_d[1] = !cs_hit[1];
    cs_d[2] = !cs_hit[2];
    drq_d[0] = run_ok && !ext && !dsel && local_drq;
    drq_d[1] = run_ok && !ext && dsel && local_drq;
    dack_d = !(run_ok && !ext && !isa_dack_n[dsel]);
  end

  // outputs registered: costs one 5 ns cycle of the 20 ns budget
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_select_a_n <= 1'b1;
      card_select_b_n <= 1'b1;
      card_select_c_n <= 1'b1;
      isa_irq <= '0;
      isa_irq_oe_n <= '1;
      isa_drq <= '0;
      local_dack_n <= 1'b1;
      isa_data_out <= '0;
      isa_data_oe_n <= 1'b1;
      pnp_interface <= 1'b1;
      write_protected <= 1'b1;
    end else begin
      card_select_a_n <= cs_d[0];
      card_select_b_n <= cs_d[1];
      card_select_c_n <= cs_d[2];
      isa_irq <= irq_d;
      isa_irq_oe_n <= irqoe_d;
      isa_drq <= drq_d;
      local_dack_n <= dack_d;
      isa_data_out <= dout_d;
      isa_data_oe_n <= doe_d;
      pnp_interface <= pnp_q;
      write_protected <= wp;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_strap_hold: assert property (st_q == pnp_frontend_pkg::ST_RUN && !isa_reset_drive
    |=> $stable(strap_q) && $stable(pnp_q)) else $error("straps moved after sampling");
  a_iface_sample: assert property (st_q == pnp_frontend_pkg::ST_SAMPLE && !isa_reset_drive
    |=> pnp_q == $past(legacy_interface_sel_n)) else $error("interface not sampled");
  a_legacy_ignore: assert property (!pnp_q && !sw_cfg && st_q == pnp_frontend_pkg::ST_RUN
    |-> !config_state && !keyok_q) else $error("legacy card entered config");
  a_wp_block: assert property (mem_wr_en && wp |-> !mem_we)
    else $error("protected memory written");
  a_wp_override: assert property (sw_cfg ##1 sw_cfg |-> !write_protected)
    else $error("protection not overridden");
  a_rd_default: assert property ($rose(config_state) && sw_cfg
    |-> rdp_q == pnp_frontend_pkg::RD_PORT_SW) else $error("read port default wrong");
  a_key_entry: assert property ($rose(config_state) && sw_cfg
    |-> $past(isa_data_in) == pnp_frontend_pkg::EXT_KEY_BYTE) else $error("bad key entry");
  a_cs_c_dma: assert property (!ext |=> card_select_c_n)
    else $error("select c active in dma mode");
  a_irq_dma_hi: assert property (!ext |=> isa_irq_oe_n[7:6] == 2'b11)
    else $error("dma mode drove channel 6 or 7");
  // open-drain channels show the request on the enable, totem ones on the level
  a_ext_route: assert property (run_ok && ext && local_irq[0]
    |=> !isa_irq_oe_n[$past(chan0)]
    && (isa_irq[$past(chan0)] || rec_q[0][pnp_frontend_pkg::QF_OD_LO + $past(chan0)]))
    else $error("ext irq not routed");
  a_dma_route: assert property (run_ok && !ext && local_drq |=> isa_drq[$past(dsel)])
    else $error("drq not routed");
endmodule // isa_pnp_resource_frontend

// ===== test/isa_host_model.sv
// Purpose: isa host side model that runs i/o read and write cycles
// Assumes: one i/o cycle at a time, strobes change just after a clock edge
// Notes: an undriven data bus shows the inverted last value, never a stale copy
`timescale 1ns/10ps
module isa_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] card_data,
  input wire logic card_oe_n,
  output logic [11:0] addr,
  output logic aen,
  output logic iord_n,
  output logic iowr_n,
  output logic [7:0] wdata
);
  logic [7:0] last_q = 8'h00;
  wire logic [7:0] bus_data = card_oe_n ? ~last_q : card_data;

  // remember what the card drove so the idle bus can differ from it
  always @(posedge sys_clk) if (!card_oe_n) last_q <= card_data;

  initial begin
    addr = 12'h000;
    aen = 1'b0;
    iord_n = 1'b1;
    iowr_n = 1'b1;
    wdata = 8'h00;
  end

  task automatic set_bus(input logic [11:0] a, input logic e, r, w, input logic [7:0] d);
    addr = a;
    aen = e;
    iord_n = r;
    iowr_n = w;
    wdata = d;
  endtask

  // data and address held through the edge that sees the strobe rise
  task automatic io_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 set_bus(a, 1'b0, 1'b1, 1'b0, d);
    @(posedge sys_clk);
    #1 iowr_n = 1'b1;
    @(posedge sys_clk);
    #1 set_bus(a, 1'b0, 1'b1, 1'b1, ~d);
  endtask

  task automatic io_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 set_bus(a, 1'b0, 1'b0, 1'b1, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 d = bus_data;
    iord_n = 1'b1;
  endtask
endmodule // isa_host_model

// ===== test/isa_pnp_resource_frontend_test.sv
// Purpose: self-checking bench for the isa resource front-end
// Assumes: records are programmed through the field-programming configuration
// Notes: random bus traffic is checked one cycle later against the stored record
`timescale 1ns/10ps
module isa_pnp_resource_frontend_test;
  // ext mode: a qualified, c wire-anded into a, irq on open-drain channel 5
  localparam logic [15:0] REC_EXT [4] = '{16'h8823, 16'h5300, 16'h5304, 16'h0308};
  // dma mode: b qualified and wire-anded, irqs on 2 (open-drain) and 4, drq 1
  localparam logic [15:0] REC_DMA [4] = '{16'h0114, 16'h2220, 16'h4224, 16'h1228};
  // pnp area: dma mode, a qualified, protected; b at 0x2a0 on irq 3
  localparam logic [15:0] REC_PNP [4] = '{16'h0002, 16'h0000, 16'h32A0, 16'h0000};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic isa_reset_drive = 1'b0;
  logic legacy_interface_sel_n = 1'b0;
  logic [4:0] legacy_strap = 5'h1F;
  logic [1:0] local_irq = 2'h0;
  logic local_drq = 1'b0;
  logic [1:0] isa_dack_n = 2'h3;
  logic mem_wr_en = 1'b0;
  logic [7:0] mem_wr_addr = 8'h00;
  logic [15:0] mem_wr_data = 16'h0000;
  logic [11:0] isa_addr;
  logic isa_aen, isa_iord_n, isa_iowr_n, isa_data_oe_n, local_dack_n;
  logic [7:0] isa_data_in, isa_data_out, isa_irq, isa_irq_oe_n, rd;
  logic [1:0] isa_drq;
  logic card_select_a_n, card_select_b_n, card_select_c_n;
  logic pnp_interface, config_state, write_protected;
  logic [15:0] rec [4];
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 38;

  always #2.5 sys_clk = ~sys_clk;

  isa_pnp_resource_frontend dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .isa_reset_drive(isa_reset_drive),
    .legacy_interface_sel_n(legacy_interface_sel_n), .legacy_strap(legacy_strap),
    .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_iord_n(isa_iord_n),
    .isa_iowr_n(isa_iowr_n), .isa_data_in(isa_data_in), .isa_data_out(isa_data_out),
    .isa_data_oe_n(isa_data_oe_n), .local_irq(local_irq), .local_drq(local_drq),
    .isa_dack_n(isa_dack_n), .local_dack_n(local_dack_n), .isa_drq(isa_drq),
    .isa_irq(isa_irq), .isa_irq_oe_n(isa_irq_oe_n), .card_select_a_n(card_select_a_n),
    .card_select_b_n(card_select_b_n), .card_select_c_n(card_select_c_n),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .pnp_interface(pnp_interface), .config_state(config_state),
    .write_protected(write_protected)
  );

  isa_host_model host (
    .sys_clk(sys_clk), .card_data(isa_data_out), .card_oe_n(isa_data_oe_n),
    .addr(isa_addr), .aen(isa_aen), .iord_n(isa_iord_n), .iowr_n(isa_iowr_n),
    .wdata(isa_data_in)
  );

  // ----------------------------------------------------------------
  // checking and expectations
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t ns %s", $time, msg);
    end
  endtask

  // active-low selects; c never hits in dma mode, wire-and folds b or c into a
  function automatic logic [2:0] exp_sel_n(input logic [11:0] a, input logic e, r, w);
    logic [2:0] hit;
    for (int i = 0; i < 3; i++) begin
      hit[i] = !e && (a == rec[i+1][11:0]) && (!rec[0][i+1] || !r || !w);
    end
    if (!rec[0][0]) hit[2] = 1'b0;
    hit[0] = hit[0] | (rec[0][4] & hit[1]) | (rec[0][5] & hit[2]);
    return ~hit;
  endfunction

  // open-drain channel pulls low only while its request is up
  function automatic logic [15:0] exp_irq(input logic [1:0] li);
    logic [7:0] v, oe;
    logic [2:0] ch;
    v = 8'h00;
    oe = 8'hFF;
    for (int k = 0; k < 2; k++) begin
      ch = rec[k+1][14:12];
      if ((k == 0 || !rec[0][0]) && !(ch > 3'd5 && !rec[0][0])) begin
        if (rec[0][6+ch]) oe[ch] = !li[k];
        else begin
          oe[ch] = 1'b0;
          v[ch] = li[k];
        end
      end
    end
    return {v, oe};
  endfunction

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic write_rec(input logic [7:0] base, input logic [15:0] w [4]);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #1 mem_wr_en = 1'b1;
      mem_wr_addr = base + 8'(i);
      mem_wr_data = w[i];
    end
    @(posedge sys_clk);
    #1 mem_wr_en = 1'b0;
  endtask

  // the 32 key bytes, worked out here from the shift rule
  task automatic send_key;
    logic [7:0] k;
    k = pnp_frontend_pkg::LFSR_SEED;
    for (int i = 0; i < 32; i++) begin
      host.io_write(pnp_frontend_pkg::ADDR_PORT, k);
      k = {k[1] ^ k[0], k[7:1]};
    end
  endtask

  // address register first, then the value through the data port
  task automatic pnp_reg(input logic [7:0] r, input logic [7:0] v);
    host.io_write(pnp_frontend_pkg::ADDR_PORT, r);
    host.io_write(pnp_frontend_pkg::WDATA_PORT, v);
  endtask

  // straps flip after the boot so a late resample would show up
  task automatic boot(input logic sel_n, input logic [4:0] code);
    @(posedge sys_clk);
    #1 legacy_interface_sel_n = sel_n;
    legacy_strap = code;
    isa_reset_drive = 1'b1;
    @(posedge sys_clk);
    #1 isa_reset_drive = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 legacy_strap = ~code;
    legacy_interface_sel_n = ~sel_n;
  endtask

  task automatic run_random(input int n);
    logic [31:0] rv;
    logic [11:0] a;
    logic e, r, w, d;
    logic [1:0] li, dk;
    a = 12'h000;
    {e, r, w, d, li, dk} = 8'h60;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1;
      if (i > 0) begin
        check({card_select_c_n, card_select_b_n, card_select_a_n} === exp_sel_n(a, e, r, w),
              "chip select decode");
        check({isa_irq, isa_irq_oe_n} === exp_irq(li), "irq routing");
        check({isa_drq, local_dack_n} === (rec[0][0] ? 3'b001 : {rec[3][12] & d,
              !rec[3][12] & d, dk[rec[3][12]]}), "dma routing");
        check({config_state, isa_data_oe_n} === 2'b01, "legacy answered protocol");
      end
      rv = $random(seed);
      a = (rv[13:12] == 2'd3) ? rv[11:0] : rec[rv[13:12] + 2'd1][11:0];
      r = rv[14];
      w = rv[14] ? rv[15] : 1'b1;
      e = (rv[18:16] == 3'd0);
      li = rv[20:19];
      d = rv[21];
      dk = rv[23:22];
      host.set_bus(a, e, r, w, rv[31:24]);
      local_irq = li;
      local_drq = d;
      isa_dack_n = dk;
    end
  endtask

  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    check({card_select_c_n, card_select_b_n, card_select_a_n, isa_irq_oe_n} === 11'h7FF,
          "reset outputs");
    check({pnp_interface, write_protected, config_state} === 3'b110, "reset status");
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 check(write_protected === 1'b0, "field programming still protected");
    send_key();
    check(config_state === 1'b0, "config without extra key byte");
    host.io_write(pnp_frontend_pkg::ADDR_PORT, 8'h9C);
    repeat (2) @(posedge sys_clk);
    #1 check(config_state === 1'b1, "extended key not taken");
    host.io_write(pnp_frontend_pkg::ADDR_PORT, pnp_frontend_pkg::REG_RD_PORT);
    host.io_read(12'h203, rd);
    check(rd === 8'h80, "default read port");
    write_rec(pnp_frontend_pkg::LEGACY_BASE_W, REC_EXT);
    write_rec(pnp_frontend_pkg::LEGACY_BASE_W + 8'h04, REC_DMA);
    write_rec(pnp_frontend_pkg::PNP_AREA_W, REC_PNP);
    boot(1'b0, 5'h00);
    rec = REC_EXT;
    check({pnp_interface, write_protected} === 2'b00, "legacy ext boot");
    run_random(3000);
    boot(1'b0, 5'h01);
    rec = REC_DMA;
    check({pnp_interface, write_protected} === 2'b01, "legacy dma boot");
    run_random(3000);
    boot(1'b1, 5'h00);
    check({pnp_interface, config_state, write_protected} === 3'b101,
          "pnp interface boot");
    send_key();
    repeat (2) @(posedge sys_clk);
    #1 check(config_state === 1'b1, "pnp key not taken");
    // config state but protected: this record must not land
    write_rec(pnp_frontend_pkg::LEGACY_BASE_W, REC_DMA);
    pnp_reg(pnp_frontend_pkg::REG_RD_PORT, 8'h80);
    pnp_reg(pnp_frontend_pkg::REG_IO_HI, 8'h03);
    pnp_reg(pnp_frontend_pkg::REG_IO_LO, 8'hE0);
    host.io_read(12'h203, rd);
    check(rd === 8'hE0, "pnp register readback");
    pnp_reg(pnp_frontend_pkg::REG_IRQ, 8'h01);
    pnp_reg(pnp_frontend_pkg::REG_DMA, 8'h01);
    pnp_reg(pnp_frontend_pkg::REG_ACTIVATE, 8'h01);
    pnp_reg(pnp_frontend_pkg::REG_CFG_CTL, 8'h02);
    // base a, irq and dma channel now come from the pnp registers
    rec = '{REC_PNP[0], 16'h13E0, REC_PNP[2], 16'h1000};
    run_random(1000);
    boot(1'b0, 5'h00);
    check({pnp_interface, write_protected} === 2'b00, "protected write landed");
    final_report();
  end
endmodule // isa_pnp_resource_frontend_test
